// ==== crq_fifo.sv ====
/*
 * crq_fifo: word fifo with a registered head word, valid/ready both sides.
 * assumes: one clock; capacity is DEPTH words in memory plus the head word.
 */
`timescale 1ns/1ps
`default_nettype none
module crq_fifo
	import crq_pkg::*;
#(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	crq_stream_if.fifo_side port
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
		logic          head_vld;
		logic [W-1:0]  head;
	} crq_fifo_st_s;

	crq_fifo_st_s state_ff;
	crq_fifo_st_s nxt_state;
	logic [W-1:0] mem [DEPTH];
	logic         push;
	logic         wr_mem;

	always_comb begin
		logic pop;
		logic refill;
		logic take_mem;
		pop       = state_ff.head_vld && port.out_ready;
		push      = port.in_valid && port.in_ready;
		refill    = !state_ff.head_vld || pop;
		take_mem  = refill && (state_ff.cnt != '0);
		nxt_state = state_ff;
		wr_mem    = push && !(refill && (state_ff.cnt == '0));
		if (take_mem) begin
			nxt_state.head     = mem[state_ff.rd];
			nxt_state.rd       = state_ff.rd + 1'b1;
			nxt_state.head_vld = 1'b1;
		end else if (refill) begin
			// empty memory: incoming word goes straight to the head
			nxt_state.head     = port.in_data;
			nxt_state.head_vld = push;
		end
		if (wr_mem) begin
			nxt_state.wr = state_ff.wr + 1'b1;
		end
		nxt_state.cnt = state_ff.cnt + (AW+1)'(wr_mem) - (AW+1)'(take_mem);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_mem) begin
			mem[state_ff.wr] <= port.in_data;
		end
	end

	assign port.in_ready  = state_ff.cnt != (AW+1)'(DEPTH);
	assign port.in_room   = state_ff.cnt < (AW+1)'(DEPTH - 1);
	assign port.out_data  = state_ff.head;
	assign port.out_valid = state_ff.head_vld;

endmodule : crq_fifo
`default_nettype wire

// ==== crq_pkg.sv ====
/*
 * crq_pkg: shared constants and types for the completer request port.
 * assumes: single ref_clk domain; imported whole by crq_fifo, crq_request_port and the testbench.
 */
package crq_pkg;

	localparam int DATA_W     = 256;
	localparam int KEEP_W     = 8;
	localparam int BYTE_W     = 32;
	localparam int SB_W       = 85;
	localparam int FIFO_DEPTH = 32;
	localparam int CREDIT_W   = 6;

	localparam logic [CREDIT_W-1:0] CREDIT_MAX = 6'h20;
	localparam logic [CREDIT_W-1:0] CREDIT_RST = 6'h00;

	// configured data path width
	localparam logic [1:0] WIDTH_64  = 2'h0;
	localparam logic [1:0] WIDTH_128 = 2'h1;
	localparam logic [1:0] WIDTH_256 = 2'h2;

	localparam logic [DATA_W-1:0] DMASK_64  = {192'h0, {64{1'b1}}};
	localparam logic [DATA_W-1:0] DMASK_128 = {128'h0, {128{1'b1}}};
	localparam logic [KEEP_W-1:0] KMASK_64  = 8'h03;
	localparam logic [KEEP_W-1:0] KMASK_128 = 8'h0f;
	localparam logic [BYTE_W-1:0] BMASK_64  = 32'h0000_00ff;
	localparam logic [BYTE_W-1:0] BMASK_128 = 32'h0000_ffff;

	// sideband field positions
	localparam int SB_FIRST_BE_LSB = 0;
	localparam int SB_LAST_BE_LSB  = 4;
	localparam int SB_BYTE_EN_LSB  = 8;
	localparam int SB_SOP_BIT      = 40;
	localparam int SB_DISC_BIT     = 41;
	localparam int SB_TPH_PRES_BIT = 42;
	localparam int SB_TPH_TYPE_LSB = 43;
	localparam int SB_TPH_TAG_LSB  = 45;
	localparam int SB_PARITY_LSB   = 53;

	localparam logic [2:0] TAG_REUSE_GAP_CYC = 3'h5;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [KEEP_W-1:0] keep;
		logic              last;
		logic              posted;
		logic              has_payload;
		logic              err;
		logic [3:0]        first_be;
		logic [3:0]        last_be;
		logic [BYTE_W-1:0] byte_en;
		logic              tph_present;
		logic [1:0]        tph_type;
		logic [7:0]        tph_st_tag;
	} crq_word_s;

	localparam int WORD_W = $bits(crq_word_s);

endpackage : crq_pkg

// ==== crq_request_port.sv ====
/*
 * crq_request_port: completer request delivery port, stream master side.
 * assumes: link words arrive on ref_clk from the receive request buffer;
 * cfg_width_mode is static while traffic flows.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01 - data 64/128/256 wide, upper bits zero
// RULE_02 - 85-bit sideband valid only with valid
// RULE_03 - last marks final beat, single-beat too
// RULE_04 - keep one bit per dword, contiguous
// RULE_05 - keep bits above width held zero
// RULE_06 - valid stays high through whole packet
// RULE_07 - beat moves only on valid and ready
// RULE_08 - stalled beat held stable with valid
// RULE_09 - credit up on grant, down per delivery
// RULE_10 - non-posted starts only with nonzero credit
// RULE_11 - posted traffic passes stalled non-posted
// RULE_12 - user pulses grant once per credit
// RULE_13 - grant needs no packet alignment
// RULE_14 - 6-bit credit level, saturates at 32
// RULE_15 - user tolerates credit level latency
// RULE_16 - five cycles before completion tag reuse
// RULE_17 - sideband bit 40 flags first beat
// RULE_18 - discontinue only on last, payload packets
// RULE_19 - odd parity per byte, unused bits zero
// RULE_20 - reset clears credit and valid
module crq_request_port
	import crq_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire logic [1:0]          cfg_width_mode,
	input  wire logic [DATA_W-1:0]   link_data,
	input  wire logic [KEEP_W-1:0]   link_keep,
	input  wire logic                link_last,
	input  wire logic                link_posted,
	input  wire logic                link_has_payload,
	input  wire logic                link_err,
	input  wire logic [3:0]          link_first_be,
	input  wire logic [3:0]          link_last_be,
	input  wire logic [BYTE_W-1:0]   link_byte_en,
	input  wire logic                link_tph_present,
	input  wire logic [1:0]          link_tph_type,
	input  wire logic [7:0]          link_tph_st_tag,
	input  wire logic                link_valid,
	output var  logic                link_ready,
	output var  logic [DATA_W-1:0]   request_stream_data,
	output var  logic [SB_W-1:0]     request_stream_sideband,
	output var  logic                request_stream_last,
	output var  logic [KEEP_W-1:0]   request_stream_dword_keep,
	output var  logic                request_stream_valid,
	input  wire logic                request_stream_ready,
	input  wire logic                nonposted_credit_grant,
	output var  logic [CREDIT_W-1:0] nonposted_credit_level,
	input  wire logic                cpl_presented,
	output var  logic                tag_reuse_blocked
);

	typedef struct packed {
		logic                valid;
		logic [DATA_W-1:0]   data;
		logic [KEEP_W-1:0]   keep;
		logic                last;
		logic [SB_W-1:0]     sb;
		logic [CREDIT_W-1:0] credit;
		logic                busy;
		logic                src_np;
		logic [CREDIT_W-1:0] pcnt;
		logic [CREDIT_W-1:0] ncnt;
		logic [2:0]          gap;
		logic                tag_block;
		logic                link_rdy;
	} crq_top_s;

	crq_top_s state_ff;
	crq_top_s nxt_state;

	crq_stream_if #(.W(WORD_W)) pf_if ();
	crq_stream_if #(.W(WORD_W)) nf_if ();

	crq_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_posted_fifo (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.port    (pf_if)
	);

	crq_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_nonposted_fifo (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.port    (nf_if)
	);

	crq_word_s         link_word;
	crq_word_s         pf_head;
	crq_word_s         nf_head;
	crq_word_s         sel_word;
	logic              link_push;
	logic              p_avail;
	logic              n_avail;
	logic              take;
	logic              sel_np;
	logic              sel_ok;
	logic              np_start;
	logic              credit_inc;
	logic [DATA_W-1:0] dmask;
	logic [KEEP_W-1:0] kmask;
	logic [BYTE_W-1:0] bmask;
	logic [DATA_W-1:0] ld_data;
	logic [BYTE_W-1:0] ld_parity;

	always_comb begin
		link_word             = '0;
		link_word.data        = link_data;
		link_word.keep        = link_keep;
		link_word.last        = link_last;
		link_word.posted      = link_posted;
		link_word.has_payload = link_has_payload;
		link_word.err         = link_err;
		link_word.first_be    = link_first_be;
		link_word.last_be     = link_last_be;
		link_word.byte_en     = link_byte_en;
		link_word.tph_present = link_tph_present;
		link_word.tph_type    = link_tph_type;
		link_word.tph_st_tag  = link_tph_st_tag;
	end

	// split by class so a starved non-posted head blocks posted only once the non-posted fifo runs out of room
	assign link_push       = link_valid && state_ff.link_rdy;
	assign pf_if.in_data   = link_word;
	assign nf_if.in_data   = link_word;
	assign pf_if.in_valid  = link_push && link_posted; // see RULE_11
	assign nf_if.in_valid  = link_push && !link_posted;
	assign pf_head         = crq_word_s'(pf_if.out_data);
	assign nf_head         = crq_word_s'(nf_if.out_data);

	always_comb begin
		case (cfg_width_mode)
			WIDTH_64: begin
				dmask = DMASK_64;
				kmask = KMASK_64;
				bmask = BMASK_64;
			end
			WIDTH_128: begin
				dmask = DMASK_128;
				kmask = KMASK_128;
				bmask = BMASK_128;
			end
			default: begin
				dmask = '1;
				kmask = '1;
				bmask = '1;
			end
		endcase
	end

	// start a packet only once it is complete (or the fifo is full) so
	// valid need not drop mid-packet
	assign p_avail  = pf_if.out_valid && (state_ff.pcnt != '0 || !pf_if.in_ready);
	assign n_avail  = nf_if.out_valid && (state_ff.ncnt != '0 || !nf_if.in_ready)
		&& (state_ff.credit != '0); // see RULE_10
	assign take     = !state_ff.valid || request_stream_ready; // see RULE_07
	assign sel_np   = state_ff.busy ? state_ff.src_np : !p_avail; // see RULE_11
	assign sel_ok   = state_ff.busy ? (sel_np ? nf_if.out_valid : pf_if.out_valid)
		: (p_avail || n_avail);
	assign sel_word = sel_np ? nf_head : pf_head;
	assign ld_data  = sel_word.data & dmask; // see RULE_01
	assign np_start = take && sel_ok && !state_ff.busy && sel_np; // see RULE_09
	assign pf_if.out_ready = take && sel_ok && !sel_np;
	assign nf_if.out_ready = take && sel_ok && sel_np;
	assign credit_inc = nonposted_credit_grant && (state_ff.credit != CREDIT_MAX); // see RULE_14

	generate
		for (genvar b = 0; b < BYTE_W; b++) begin : g_parity
			assign ld_parity[b] = bmask[b] & ~^ld_data[8*b +: 8]; // see RULE_19
		end
	endgenerate

	always_comb begin
		nxt_state = state_ff;
		if (take && sel_ok) begin
			nxt_state.valid  = 1'b1;
			nxt_state.data   = ld_data;
			nxt_state.keep   = sel_word.keep & kmask; // see RULE_04, RULE_05
			nxt_state.last   = sel_word.last; // see RULE_03
			nxt_state.busy   = !sel_word.last; // see RULE_06
			nxt_state.src_np = sel_np;
			nxt_state.sb     = '0;
			nxt_state.sb[SB_FIRST_BE_LSB +: 4] = sel_word.first_be;
			nxt_state.sb[SB_LAST_BE_LSB +: 4]  = sel_word.last_be;
			nxt_state.sb[SB_BYTE_EN_LSB +: BYTE_W] = sel_word.byte_en & bmask;
			nxt_state.sb[SB_SOP_BIT] = !state_ff.busy; // see RULE_17
			nxt_state.sb[SB_DISC_BIT] = sel_word.err && sel_word.last
				&& sel_word.has_payload; // see RULE_18
			nxt_state.sb[SB_TPH_PRES_BIT]     = sel_word.tph_present;
			nxt_state.sb[SB_TPH_TYPE_LSB +: 2] = sel_word.tph_type;
			nxt_state.sb[SB_TPH_TAG_LSB +: 8]  = sel_word.tph_st_tag;
			nxt_state.sb[SB_PARITY_LSB +: BYTE_W] = ld_parity;
		end else if (take) begin
			// idle beat re-masked: a width change must not expose stale upper bits
			nxt_state.valid = 1'b0; // see RULE_02
			nxt_state.data  = state_ff.data & dmask; // see RULE_01
			nxt_state.keep  = state_ff.keep & kmask; // see RULE_05
			nxt_state.sb[SB_BYTE_EN_LSB +: BYTE_W] =
				state_ff.sb[SB_BYTE_EN_LSB +: BYTE_W] & bmask;
			nxt_state.sb[SB_PARITY_LSB +: BYTE_W] =
				state_ff.sb[SB_PARITY_LSB +: BYTE_W] & bmask; // see RULE_19
		end
		// a stalled beat is left untouched: see RULE_08
		nxt_state.credit = state_ff.credit + CREDIT_W'(credit_inc)
			- CREDIT_W'(np_start); // see RULE_09, RULE_13
		nxt_state.pcnt = state_ff.pcnt + CREDIT_W'(pf_if.in_valid && link_last)
			- CREDIT_W'(pf_if.out_ready && pf_head.last);
		nxt_state.ncnt = state_ff.ncnt + CREDIT_W'(nf_if.in_valid && link_last)
			- CREDIT_W'(nf_if.out_ready && nf_head.last);
		// one push may land on the stale ready, so keep a spare slot
		nxt_state.link_rdy = pf_if.in_room && nf_if.in_room;
		if (cpl_presented) begin
			nxt_state.gap = TAG_REUSE_GAP_CYC; // see RULE_16
		end else if (state_ff.gap != '0) begin
			nxt_state.gap = state_ff.gap - 3'h1;
		end
		nxt_state.tag_block = cpl_presented || (state_ff.gap > 3'h1);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= '0; // see RULE_20
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign link_ready                = state_ff.link_rdy;
	assign request_stream_data       = state_ff.data;
	assign request_stream_sideband   = state_ff.sb;
	assign request_stream_last       = state_ff.last;
	assign request_stream_dword_keep = state_ff.keep;
	assign request_stream_valid      = state_ff.valid;
	assign nonposted_credit_level    = state_ff.credit;
	assign tag_reuse_blocked         = state_ff.tag_block;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	logic np_start_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			np_start_q <= 1'b0;
		end else begin
			np_start_q <= np_start;
		end
	end

	a_stall_hold: assert property ( // see RULE_08
		request_stream_valid && !request_stream_ready |=> request_stream_valid
			&& $stable(request_stream_data) && $stable(request_stream_sideband)
			&& $stable(request_stream_last) && $stable(request_stream_dword_keep))
		else $error("stalled beat changed");

	a_no_gap: assert property ( // see RULE_06
		request_stream_valid && request_stream_ready && !request_stream_last
			|=> request_stream_valid)
		else $error("valid dropped inside a packet");

	a_upper_128: assert property ( // see RULE_01
		$stable(cfg_width_mode) && cfg_width_mode == WIDTH_128
			|=> request_stream_data[255:128] == '0 && request_stream_dword_keep[7:4] == '0)
		else $error("upper bits set in 128-bit mode");

	a_upper_64: assert property ( // see RULE_05
		$stable(cfg_width_mode) && cfg_width_mode == WIDTH_64
			|=> request_stream_data[255:64] == '0 && request_stream_dword_keep[7:2] == '0
			&& request_stream_sideband[84:61] == '0)
		else $error("upper bits set in 64-bit mode");

	a_keep_full: assert property ( // see RULE_04
		$stable(cfg_width_mode) && request_stream_valid && !request_stream_last
			|-> request_stream_dword_keep == $past(kmask))
		else $error("keep not full before last beat");

	a_credit_sat: assert property ( // see RULE_14
		nonposted_credit_level <= CREDIT_MAX)
		else $error("credit above saturation");

	a_credit_use: assert property ( // see RULE_10
		np_start_q |-> $past(nonposted_credit_level) != '0
			&& nonposted_credit_level == $past(nonposted_credit_level)
			- 6'h01 + 6'($past(credit_inc)))
		else $error("non-posted start without credit");

	a_credit_grant: assert property ( // see RULE_09
		nonposted_credit_grant && nonposted_credit_level < CREDIT_MAX && !np_start
			|=> nonposted_credit_level == $past(nonposted_credit_level) + 6'h01)
		else $error("grant not counted");

	a_disc_last: assert property ( // see RULE_18
		request_stream_valid && request_stream_sideband[SB_DISC_BIT]
			|-> request_stream_last)
		else $error("discontinue off the last beat");

	a_sop_next: assert property ( // see RULE_17
		request_stream_valid && request_stream_ready && request_stream_last
			##1 request_stream_valid |-> request_stream_sideband[SB_SOP_BIT])
		else $error("first beat without start flag");

	a_parity_b0: assert property ( // see RULE_19
		request_stream_valid
			|-> ^{request_stream_data[7:0], request_stream_sideband[SB_PARITY_LSB]})
		else $error("byte 0 parity not odd");

	a_tag_gap: assert property ( // see RULE_16
		cpl_presented |=> tag_reuse_blocked [*5])
		else $error("tag reuse window too short");

	a_tag_release: assert property ( // see RULE_16
		cpl_presented ##1 !cpl_presented [*5] |=> !tag_reuse_blocked)
		else $error("tag reuse window never closes");

	a_keep_contig: assert property ( // see RULE_04
		request_stream_valid
			|-> (request_stream_dword_keep & (request_stream_dword_keep + 8'h01)) == '0)
		else $error("keep not contiguous from dword 0");

	a_sop_clear: assert property ( // see RULE_17
		request_stream_valid && request_stream_ready && !request_stream_last
			|=> !request_stream_sideband[SB_SOP_BIT])
		else $error("start flag on a later beat");

	a_link_room: assert property ( // see RULE_07
		link_valid && link_ready |-> (link_posted ? pf_if.in_ready : nf_if.in_ready))
		else $error("link beat taken into a full fifo");

	c_backpressure: cover property (
		request_stream_valid && !request_stream_ready ##1 request_stream_ready);
	c_posted_pass: cover property (
		nonposted_credit_level == '0 && nf_if.out_valid && pf_if.out_ready);
	c_np_start: cover property (np_start);
	c_multi_beat: cover property (request_stream_valid && request_stream_ready && !request_stream_last);
	c_credit_full: cover property (nonposted_credit_level == CREDIT_MAX);

endmodule : crq_request_port
`default_nettype wire

// ==== crq_stream_if.sv ====
/*
 * crq_stream_if: valid/ready word channel into and out of a request fifo.
 * assumes: both ends on the same clock; W matches the fifo word width.
 */
`timescale 1ns/1ps
`default_nettype none
interface crq_stream_if #(parameter int W = 8);
	logic [W-1:0] in_data;
	logic         in_valid;
	logic         in_ready;
	logic         in_room;
	logic [W-1:0] out_data;
	logic         out_valid;
	logic         out_ready;

	modport fifo_side (input in_data, in_valid, out_ready,
		output in_ready, in_room, out_data, out_valid);
	modport user_side (output in_data, in_valid, out_ready,
		input in_ready, in_room, out_data, out_valid);
endinterface : crq_stream_if
`default_nettype wire

// ==== crq_user_model.sv ====
/*
 * crq_user_model: user logic consuming the request stream and granting credit.
 * assumes: shares ref_clk with the port; the bench picks ready pacing.
 */
`timescale 1ns/1ps
`default_nettype none
module crq_user_model (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] ready_mode,
	input  wire logic       credit_add,
	input  wire logic       grant_hold,
	output var  logic       request_stream_ready,
	output var  logic       nonposted_credit_grant
);
	int pending;

	// the credit level is never read here: it lags the grants
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pending = 0;
			request_stream_ready <= 1'h0;
			nonposted_credit_grant <= 1'h0;
		end else begin
			if (credit_add)
				pending++;
			if (grant_hold) begin
				nonposted_credit_grant <= 1'h1;
			end else if (pending > 0 && !nonposted_credit_grant) begin
				nonposted_credit_grant <= 1'h1;
				pending--;
			end else begin
				nonposted_credit_grant <= 1'h0;
			end
			case (ready_mode)
				2'h0: request_stream_ready <= 1'h1;
				2'h1: request_stream_ready <= 1'($urandom_range(1));
				default: request_stream_ready <= 1'h0;
			endcase
		end
	end
endmodule : crq_user_model
`default_nettype wire

// ==== testbench.sv ====
/*
 * testbench: self-checking bench for the completer request port.
 * assumes: crq_pkg, crq_stream_if, crq_fifo and crq_user_model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import crq_pkg::*;
;
	logic                ref_clk;
	logic                reset_n;
	logic [1:0]          cfg_width_mode;
	crq_word_s           lw;
	logic                link_valid;
	logic                link_ready;
	logic [DATA_W-1:0]   request_stream_data;
	logic [SB_W-1:0]     request_stream_sideband;
	logic                request_stream_last;
	logic [KEEP_W-1:0]   request_stream_dword_keep;
	logic                request_stream_valid;
	logic                request_stream_ready;
	logic                nonposted_credit_grant;
	logic [CREDIT_W-1:0] nonposted_credit_level;
	logic                cpl_presented;
	logic                tag_reuse_blocked;
	logic [1:0]          ready_mode;
	logic                credit_add;
	logic                grant_hold;
	crq_word_s           pq[$];
	crq_word_s           nq[$];
	int                  credit;
	int                  bad_count;
	int                  check_count;
	bit                  mid;
	bit                  held;
	bit                  stall_seen;
	logic [349:0]        prev;

	crq_request_port u_crq_request_port (
		.ref_clk(ref_clk), .reset_n(reset_n), .cfg_width_mode(cfg_width_mode),
		.link_data(lw.data), .link_keep(lw.keep), .link_last(lw.last),
		.link_posted(lw.posted), .link_has_payload(lw.has_payload), .link_err(lw.err),
		.link_first_be(lw.first_be), .link_last_be(lw.last_be), .link_byte_en(lw.byte_en),
		.link_tph_present(lw.tph_present), .link_tph_type(lw.tph_type),
		.link_tph_st_tag(lw.tph_st_tag), .link_valid(link_valid), .link_ready(link_ready),
		.request_stream_data(request_stream_data),
		.request_stream_sideband(request_stream_sideband),
		.request_stream_last(request_stream_last),
		.request_stream_dword_keep(request_stream_dword_keep),
		.request_stream_valid(request_stream_valid),
		.request_stream_ready(request_stream_ready),
		.nonposted_credit_grant(nonposted_credit_grant),
		.nonposted_credit_level(nonposted_credit_level),
		.cpl_presented(cpl_presented), .tag_reuse_blocked(tag_reuse_blocked));

	crq_user_model u_crq_user_model (
		.ref_clk(ref_clk), .reset_n(reset_n), .ready_mode(ready_mode),
		.credit_add(credit_add), .grant_hold(grant_hold),
		.request_stream_ready(request_stream_ready),
		.nonposted_credit_grant(nonposted_credit_grant));

	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string n, input logic [511:0] x, input logic [511:0] g);
		check_count++;
		if (x !== g) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", n, x, g);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic take_beat();
		crq_word_s         e;
		logic [DATA_W-1:0] xd;
		logic [SB_W-1:0]   xs;
		logic [SB_W-1:0]   sm;
		logic [BYTE_W-1:0] bm;
		logic [KEEP_W-1:0] km;
		logic              p;
		p = request_stream_data[0];
		if ((p ? pq.size() : nq.size()) == 0) begin
			chk("queued beat", 1, 0);
			return;
		end
		e = p ? pq.pop_front() : nq.pop_front();
		if (!p && !mid) begin
			chk("np credit", 1, credit > 0);
			credit--;
		end
		bm = cfg_width_mode == WIDTH_64 ? BMASK_64 : cfg_width_mode == WIDTH_128 ? BMASK_128 : '1;
		km = cfg_width_mode == WIDTH_64 ? KMASK_64 : cfg_width_mode == WIDTH_128 ? KMASK_128 : '1;
		xd = e.data & (cfg_width_mode == WIDTH_64 ? DMASK_64 :
			cfg_width_mode == WIDTH_128 ? DMASK_128 : '1);
		xs = {e.tph_st_tag, e.tph_type, e.tph_present, e.err & e.has_payload & e.last, !mid,
			e.byte_en & bm, e.last_be, e.first_be};
		for (int i = 0; i < BYTE_W; i++)
			xs[SB_PARITY_LSB + i] = bm[i] & ~^xd[8*i +: 8];
		sm = '1;
		if (mid) begin
			sm[52:42] = '0;
			sm[7:0] = '0;
		end
		chk("data", xd, request_stream_data);
		chk("keep", e.keep & km, request_stream_dword_keep);
		chk("last", e.last, request_stream_last);
		chk("sideband", xs & sm, request_stream_sideband & sm);
		mid = !e.last;
	endtask : take_beat

	always @(posedge ref_clk) begin
		if (reset_n) begin
			if (nonposted_credit_grant === 1'h1 && credit < 32)
				credit++;
			if (link_valid && link_ready === 1'h1 && lw.posted)
				pq.push_back(lw);
			if (link_valid && link_ready === 1'h1 && !lw.posted)
				nq.push_back(lw);
			if (link_valid && link_ready === 1'h0)
				stall_seen = 1'h1;
			if (mid)
				chk("valid in packet", 1, request_stream_valid);
			if (held)
				chk("stalled beat", prev, {request_stream_last, request_stream_dword_keep,
					request_stream_sideband, request_stream_data});
			held = request_stream_valid === 1'h1 && request_stream_ready === 1'h0;
			prev = {request_stream_last, request_stream_dword_keep,
				request_stream_sideband, request_stream_data};
			if (request_stream_valid === 1'h1 && request_stream_ready === 1'h1)
				take_beat();
		end
	end

	// fields other than data, keep and last stay per packet; error shows on the last beat only
	task automatic send_pkt(input logic p, input int n);
		logic [WORD_W+31:0] r;
		crq_word_s          w;
		for (int i = 0; i < WORD_W / 32 + 1; i++)
			r[32*i +: 32] = $urandom;
		w = r[WORD_W-1:0];
		for (int b = 0; b < n; b++) begin
			for (int i = 0; i < DATA_W / 32; i++)
				w.data[32*i +: 32] = $urandom;
			w.data[0] = p;
			w.posted = p;
			w.last = b == n - 1;
			w.keep = w.last ? 8'hff >> $urandom_range(7) : 8'hff;
			w.err = r[WORD_W] & w.last;
			lw <= w;
			link_valid <= 1'h1;
			for (int t = 0; t < 400; t++) begin
				@(posedge ref_clk);
				if (link_ready === 1'h1)
					break;
				if (t == 399)
					chk("link ready", 1, 0);
			end
		end
		link_valid <= 1'h0;
		@(posedge ref_clk);
	endtask : send_pkt

	task automatic wait_q(input int n);
		for (int t = 0; t < 600 && pq.size() + nq.size() != n; t++)
			@(posedge ref_clk);
		repeat (8) @(posedge ref_clk);
	endtask : wait_q

	task automatic give(input int n);
		repeat (n) begin
			credit_add <= 1'h1;
			@(posedge ref_clk);
			credit_add <= 1'h0;
			@(posedge ref_clk);
		end
	endtask : give

	initial begin
		#2000000;
		bad_count++;
		end_sim();
	end

	initial begin
		reset_n = 1'h0;
		cfg_width_mode = WIDTH_256;
		lw = '0;
		link_valid = 1'h0;
		ready_mode = 2'h0;
		credit_add = 1'h0;
		grant_hold = 1'h0;
		cpl_presented = 1'h0;
		void'($urandom(49727));
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'h1;
		repeat (2) @(posedge ref_clk);
		chk("level after reset", 0, nonposted_credit_level);
		chk("valid after reset", 0, request_stream_valid);
		send_pkt(1'h0, 2);
		repeat (20) @(posedge ref_clk);
		chk("np without credit", 0, request_stream_valid);
		send_pkt(1'h1, 3);
		wait_q(2);
		chk("posted passes", 1, nq.size() == 2 && pq.size() == 0);
		give(1);
		wait_q(0);
		chk("level after np", credit, nonposted_credit_level);
		for (int m = 0; m < 3; m++) begin
			cfg_width_mode <= m[1:0];
			ready_mode <= 2'h1;
			for (int k = 0; k < 12; k++) begin
				if (k % 3 != 0)
					give(1);
				send_pkt(k % 3 == 0, 1 + $urandom_range(3));
			end
			wait_q(0);
			chk("all delivered", 0, pq.size() + nq.size());
			chk("level", credit, nonposted_credit_level);
		end
		stall_seen = 1'h0;
		ready_mode <= 2'h2;
		fork
			begin
				repeat (150) @(posedge ref_clk);
				ready_mode <= 2'h0;
			end
		join_none
		for (int k = 0; k < 40; k++)
			send_pkt(1'h1, 1);
		wait_q(0);
		chk("fifo refused", 1, stall_seen);
		chk("fifo drained", 0, pq.size());
		cpl_presented <= 1'h1;
		@(posedge ref_clk);
		cpl_presented <= 1'h0;
		for (int i = 1; i <= 6; i++) begin
			#1;
			chk("tag blocked", i <= 5, tag_reuse_blocked);
			@(posedge ref_clk);
		end
		grant_hold <= 1'h1;
		repeat (40) @(posedge ref_clk);
		grant_hold <= 1'h0;
		repeat (8) @(posedge ref_clk);
		chk("level saturated", 6'h20, nonposted_credit_level);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
